//--- design/adc_device_end.sv
// Converter end: conversion sequencing, calibration and serial result readout.
`timescale 1ns/100ps
`include "adc_params.svh"
module adc_device_end #(
  parameter int unsigned FAST_CONV_CYC = `FAST_CONV_CYC,
  parameter int unsigned SLOW_CONV_CYC = `SLOW_CONV_CYC,
  parameter int unsigned CAL_CYC = `CAL_CYC,
  parameter int unsigned UPDATE_CYC = `UPDATE_WINDOW_CYC,
  parameter int unsigned AVG_N = `AVG_SAMPLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  adc_link_if.device link,
  input wire logic signed [31:0] sample_in,
  output logic converting,
  output logic calibrating,
  output adc_pkg::result_t last_result
);
  adc_pkg::dev_state_e state_q;
  logic start_m_q, start_s_q;
  logic mode_m_q, mode_s_q;
  logic sclk_m_q, sclk_s_q, sclk_p_q;
  logic sclk_rise, sclk_fall;
  logic mode_q;
  logic pin_q;
  logic [4:0] sclk_cnt_q;
  logic cal_trig;
  logic signed [35:0] acc_q;
  logic signed [35:0] sample_ext;
  adc_pkg::result_t held_q;
  adc_pkg::result_t shreg_q;
  adc_pkg::result_t conv_result;
  logic tmr_load, tmr_done;
  logic [31:0] tmr_val;
  logic [31:0] tmr_remain;
  logic conv_end, upd_end, cal_end;

  // Link inputs come from the host's clock domain, so each passes two flops.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      start_m_q <= 1'b0;
      start_s_q <= 1'b0;
      mode_m_q <= 1'b0;
      mode_s_q <= 1'b0;
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
    end else begin
      start_m_q <= link.start;
      start_s_q <= start_m_q;
      mode_m_q <= link.mode;
      mode_s_q <= mode_m_q;
      sclk_m_q <= link.sclk;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
    end
  end

  assign sclk_rise = sclk_s_q && !sclk_p_q;
  assign sclk_fall = !sclk_s_q && sclk_p_q;
  assign cal_trig = sclk_fall && (sclk_cnt_q == `SCLK_COUNT_CAL);

  assign conv_end = (state_q == adc_pkg::DEV_CONV) && tmr_done;
  assign cal_end = (state_q == adc_pkg::DEV_CAL) && tmr_done;
  assign upd_end = (state_q == adc_pkg::DEV_UPDATE) && tmr_done;

  // All intervals run from this clock alone; shift clocks never advance them.
  conv_timer #(
    .WIDTH(32)
  ) u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(tmr_load),
    .load_val(tmr_val),
    .running(),
    .done(tmr_done),
    .remain(tmr_remain)
  );

  always_comb begin
    tmr_load = 1'b0;
    tmr_val = 32'h00000000;
    if (cal_trig) begin
      tmr_load = 1'b1;
      tmr_val = 32'(CAL_CYC);
    end else if (conv_end || cal_end) begin
      tmr_load = 1'b1;
      tmr_val = 32'(UPDATE_CYC);
    end else if ((state_q == adc_pkg::DEV_OFF && start_s_q) || (upd_end && start_s_q)) begin
      tmr_load = 1'b1;
      tmr_val = mode_s_q ? 32'(FAST_CONV_CYC) : 32'(SLOW_CONV_CYC);
    end
  end

  // Calibration may cut into a running conversion; it always takes priority.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= adc_pkg::DEV_OFF;
    end else if (cal_trig) begin
      state_q <= adc_pkg::DEV_CAL;
    end else begin
      unique case (state_q)
        adc_pkg::DEV_OFF: begin
          if (start_s_q) begin
            state_q <= adc_pkg::DEV_CONV;
          end
        end
        adc_pkg::DEV_CONV: begin
          if (tmr_done) begin
            state_q <= adc_pkg::DEV_UPDATE;
          end
        end
        adc_pkg::DEV_CAL: begin
          if (tmr_done) begin
            state_q <= adc_pkg::DEV_UPDATE;
          end
        end
        adc_pkg::DEV_UPDATE: begin
          if (tmr_done) begin
            state_q <= start_s_q ? adc_pkg::DEV_CONV : adc_pkg::DEV_OFF;
          end
        end
      endcase
    end
  end

  // Mode is frozen for the whole conversion so a mid-way change cannot mix rates.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 1'b0;
    end else if (tmr_load && (state_q == adc_pkg::DEV_OFF || upd_end)) begin
      mode_q <= mode_s_q;
    end
  end

  assign sample_ext = {{4{sample_in[31]}}, sample_in};

  // Low-noise mode sums the last samples of the conversion and averages them.
  // The window sits one count early so every sample lands before the result is taken.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc_q <= 36'sh000000000;
    end else if (state_q != adc_pkg::DEV_CONV) begin
      acc_q <= 36'sh000000000;
    end else if (!mode_q && tmr_remain <= 32'(AVG_N + 1) && tmr_remain > 32'h00000001) begin
      acc_q <= acc_q + sample_ext;
    end
  end

  function automatic adc_pkg::result_t saturate(input logic signed [35:0] v);
    if (v > 36'sh0007FFFFF) begin
      saturate = `CODE_POS_FS;
    end else if (v < -36'sh000800000) begin
      saturate = `CODE_NEG_FS;
    end else begin
      saturate = v[23:0];
    end
  endfunction

  assign conv_result = mode_q ? saturate(sample_ext) : saturate(acc_q >>> `AVG_SHIFT);

  // The finished result waits here through the update window before release.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      held_q <= 24'h000000;
    end else if (cal_end) begin
      held_q <= `CODE_CAL;
    end else if (conv_end) begin
      held_q <= conv_result;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      last_result <= 24'h000000;
    end else if (upd_end) begin
      last_result <= held_q;
    end
  end

  // Shift clocks are counted per result; counting past the calibration edge stops.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_cnt_q <= `SCLK_COUNT_IDLE;
    end else if (upd_end) begin
      sclk_cnt_q <= 5'h00;
    end else if (cal_trig) begin
      sclk_cnt_q <= `SCLK_COUNT_IDLE;
    end else if (sclk_rise && sclk_cnt_q < `SCLK_COUNT_CAL) begin
      sclk_cnt_q <= sclk_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shreg_q <= 24'h000000;
    end else if (upd_end) begin
      shreg_q <= held_q;
    end else if (sclk_rise && sclk_cnt_q < `RESULT_BITS) begin
      shreg_q <= {shreg_q[22:0], 1'b0};
    end
  end

  // An unread result is lost when the next update begins; the host must hurry.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 1'b1;
    end else if (conv_end || cal_end) begin
      pin_q <= 1'b1;
    end else if (upd_end) begin
      pin_q <= 1'b0;
    end else if (sclk_rise && sclk_cnt_q < `RESULT_BITS) begin
      pin_q <= shreg_q[23];
    end else if (sclk_rise && sclk_cnt_q == `SCLK_COUNT_FORCE) begin
      pin_q <= 1'b1;
    end
  end

  assign link.ready_and_serial_out = pin_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      converting <= 1'b0;
      calibrating <= 1'b0;
    end else begin
      converting <= (state_q != adc_pkg::DEV_OFF);
      calibrating <= (state_q == adc_pkg::DEV_CAL);
    end
  end
endmodule // adc_device_end

//--- design/adc_host_end.sv
// Host end: drives start and mode, makes the shift clock, collects results.
`timescale 1ns/100ps
`include "adc_params.svh"
module adc_host_end #(
  parameter int unsigned SCLK_HALF = `SCLK_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  adc_link_if.host link,
  input wire logic mode_sel,
  input wire logic continuous,
  input wire logic single_req,
  input wire logic cal_req,
  output adc_pkg::result_t result_q,
  output logic result_valid_q,
  output logic cal_done_q,
  output logic busy
);
  adc_pkg::host_state_e state_q;
  logic rdy_m_q, rdy_s_q;
  logic pulse_load, pulse_run;
  logic cal_hold_q, cal_pend_q;
  logic mode_q, sclk_q;
  logic [7:0] ph_q;
  logic [4:0] nclk_q;
  logic period_end;
  adc_pkg::result_t sh_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdy_m_q <= 1'b1;
      rdy_s_q <= 1'b1;
    end else begin
      rdy_m_q <= link.ready_and_serial_out;
      rdy_s_q <= rdy_m_q;
    end
  end

  assign pulse_load = single_req && !pulse_run;

  conv_timer #(
    .WIDTH(32)
  ) u_pulse (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(pulse_load),
    .load_val(32'(`START_PULSE_CYC)),
    .running(pulse_run),
    .done(),
    .remain()
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 1'b0;
    end else begin
      mode_q <= mode_sel;
    end
  end

  // Start stays high from the request until calibration reports ready again.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cal_hold_q <= 1'b0;
      cal_pend_q <= 1'b0;
    end else if (cal_req) begin
      cal_hold_q <= 1'b1;
      cal_pend_q <= 1'b1;
    end else if (state_q == adc_pkg::HOST_CAL && !rdy_s_q) begin
      cal_hold_q <= 1'b0;
    end else if (state_q == adc_pkg::HOST_SHIFT && period_end
                 && nclk_q == `SCLK_COUNT_CAL - 5'h01) begin
      cal_pend_q <= 1'b0;
    end
  end

  assign period_end = (state_q == adc_pkg::HOST_SHIFT) && (ph_q == 8'(2 * SCLK_HALF - 1));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= adc_pkg::HOST_IDLE;
      ph_q <= 8'h00;
      nclk_q <= 5'h00;
    end else begin
      unique case (state_q)
        adc_pkg::HOST_IDLE: begin
          ph_q <= 8'h00;
          nclk_q <= 5'h00;
          if (!rdy_s_q) begin
            state_q <= adc_pkg::HOST_SHIFT;
          end
        end
        adc_pkg::HOST_SHIFT: begin
          ph_q <= period_end ? 8'h00 : ph_q + 8'h01;
          if (period_end) begin
            nclk_q <= nclk_q + 5'h01;
            if (cal_pend_q && nclk_q == `SCLK_COUNT_CAL - 5'h01) begin
              state_q <= adc_pkg::HOST_CAL;
            end else if (!cal_pend_q && nclk_q == `SCLK_COUNT_FORCE) begin
              state_q <= adc_pkg::HOST_IDLE;
            end
          end
        end
        adc_pkg::HOST_CAL: begin
          if (!rdy_s_q) begin
            state_q <= adc_pkg::HOST_IDLE;
          end
        end
      endcase
    end
  end

  // Bits are taken at the end of each low phase, long after the device moved.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sh_q <= 24'h000000;
      result_q <= 24'h000000;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= 1'b0;
      if (period_end && nclk_q < `RESULT_BITS) begin
        sh_q <= {sh_q[22:0], rdy_s_q};
        if (nclk_q == `RESULT_BITS - 5'h01) begin
          result_q <= {sh_q[22:0], rdy_s_q};
          result_valid_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      cal_done_q <= 1'b0;
    end else begin
      sclk_q <= (state_q == adc_pkg::HOST_SHIFT) && !period_end && (ph_q < 8'(SCLK_HALF - 1));
      cal_done_q <= (state_q == adc_pkg::HOST_CAL) && !rdy_s_q;
    end
  end

  assign link.start = continuous || pulse_run || cal_hold_q;
  assign link.mode = mode_q;
  assign link.sclk = sclk_q;
  assign busy = (state_q != adc_pkg::HOST_IDLE) || pulse_run;
endmodule // adc_host_end

//--- design/adc_link_if.sv
// Two-wire read link plus start and mode lines between host and converter.
`timescale 1ns/100ps
interface adc_link_if;
  logic start;
  logic mode;
  logic sclk;
  logic ready_and_serial_out;
  modport device (input start, input mode, input sclk, output ready_and_serial_out);
  modport host (output start, output mode, output sclk, input ready_and_serial_out);
endinterface

//--- design/adc_params.svh
// Timing counts, field values and bit counts for the converter link.
// Function
// - Low on combined pin marks new result.
// - First rise after ready shifts MSB first.
// - Twenty-fifth clock forces pin high until ready.
// - Without it, last bit holds until update.
// - Mode high fast, low averaged low-noise.
// - Host holds start high at least 17 us.
// - Fast conversion takes 8.0 to 13.3 ms.
// - Low-noise conversion takes 45.5 to 83.3 ms.
// - Power down after conversion until start high.
// - Start held high converts back to back.
// - Result is 24-bit two's complement.
// - Saturate to full-scale codes at extremes.
// - Host waits ready, finishes before next update.
// - Host never reads during the update window.
// - Calibration begins on 26th clock falling edge.
// - Host keeps start high through calibration.
// - Calibration ends with ready, internal inputs.
// - First ready 187 to 313 ms after calibration.
// - Host keeps shift clocks quiet while calibrating.
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

`define CLK_MHZ 100
`define START_PULSE_WIDTH_US 17
`define START_PULSE_CYC (`START_PULSE_WIDTH_US * `CLK_MHZ)
`define SCLK_PULSE_MIN_NS 100
`define SCLK_HALF_CYC ((`SCLK_PULSE_MIN_NS * `CLK_MHZ + 999) / 1000)
`define UPDATE_WINDOW_MIN_US_X10 295
`define UPDATE_WINDOW_CYC ((`UPDATE_WINDOW_MIN_US_X10 * `CLK_MHZ + 9) / 10)
`define FAST_CONV_MIN_MS_X10 80
`define FAST_CONV_CYC (`FAST_CONV_MIN_MS_X10 * `CLK_MHZ * 100)
`define SLOW_CONV_MIN_MS_X10 455
`define SLOW_CONV_CYC (`SLOW_CONV_MIN_MS_X10 * `CLK_MHZ * 100)
`define CAL_MIN_MS 187
`define CAL_CYC (`CAL_MIN_MS * `CLK_MHZ * 1000)
`define AVG_SHIFT 4
`define AVG_SAMPLES 16
`define RESULT_BITS 5'd24
`define SCLK_COUNT_FORCE 5'd24
`define SCLK_COUNT_CAL 5'd26
`define SCLK_COUNT_IDLE 5'd27
`define CODE_POS_FS 24'h7FFFFF
`define CODE_NEG_FS 24'h800000
`define CODE_CAL 24'h000000

`endif

//--- design/adc_pkg.sv
// Shared types of the converter link ends.
package adc_pkg;
  typedef logic [23:0] result_t;
  typedef enum logic [1:0] {DEV_OFF, DEV_CONV, DEV_UPDATE, DEV_CAL} dev_state_e;
  typedef enum logic [1:0] {HOST_IDLE, HOST_SHIFT, HOST_CAL} host_state_e;
endpackage

//--- design/conv_timer.sv
// Loadable down-counter that times one interval from the system clock.
`timescale 1ns/100ps
module conv_timer #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic running,
  output logic done,
  output logic [WIDTH-1:0] remain
);
  logic [WIDTH-1:0] cnt_q;
  logic run_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      run_q <= (load_val != '0);
    end else if (run_q) begin
      cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
      if (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        run_q <= 1'b0;
      end
    end
  end

  assign running = run_q;
  assign done = run_q && (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
  assign remain = cnt_q;
endmodule // conv_timer

//--- verification/adc_link_checker.sv
// Concurrent checks on the link between the host end and the converter end.
`timescale 1ns/100ps
`include "adc_params.svh"
module adc_link_checker #(
  parameter int unsigned FAST_CONV_CYC = `FAST_CONV_CYC,
  parameter int unsigned SLOW_CONV_CYC = `SLOW_CONV_CYC,
  parameter int unsigned CAL_CYC = `CAL_CYC,
  parameter int unsigned UPDATE_CYC = `UPDATE_WINDOW_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic mode,
  input wire logic sclk,
  input wire logic ready_and_serial_out
);
  localparam int unsigned START_MIN = `START_PULSE_CYC;
  localparam int unsigned LO = 4;
  localparam int unsigned HI = 12;
  logic sclk_d_q, start_d_q, pin_d_q, armed_q;
  logic [4:0] cnt_q;
  logic [1:0] kind_q;
  int unsigned since_q, run_q;
  logic rise, ready_fall, cal_fall, start_rise, restart;
  // A fall of the pin is a ready only outside a read, since data bits fall too.
  assign rise = sclk && !sclk_d_q;
  assign ready_fall = pin_d_q && !ready_and_serial_out && (cnt_q == 5'h0 || cnt_q >= 5'h19);
  assign cal_fall = sclk_d_q && !sclk && cnt_q == 5'h1A;
  assign start_rise = start && !start_d_q;
  assign restart = ready_fall || cal_fall || start_rise;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_d_q <= 1'b0;
      start_d_q <= 1'b0;
      pin_d_q <= 1'b1;
    end else begin
      sclk_d_q <= sclk;
      start_d_q <= start;
      pin_d_q <= ready_and_serial_out;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 5'h0;
    end else if (ready_fall) begin
      cnt_q <= 5'h0;
    end else if (rise && cnt_q != 5'h1F) begin
      cnt_q <= cnt_q + 5'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      since_q <= 0;
      kind_q <= 2'h0;
      armed_q <= 1'b0;
      run_q <= 0;
    end else begin
      since_q <= restart ? 0 : since_q + 1;
      if (cal_fall) begin
        kind_q <= 2'h2;
      end else if (restart) begin
        kind_q <= {1'b0, mode};
      end
      if (start_rise || cal_fall) begin
        armed_q <= 1'b1;
      end else if (ready_fall) begin
        armed_q <= start;
      end
      run_q <= start ? run_q + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_forced_high;
    ##[1:6] ready_and_serial_out ##1 ready_and_serial_out [*8];
  endsequence
  sequence s_bit_stands;
    ##6 $stable(ready_and_serial_out) [*8];
  endsequence
  a_ready_stays_low: assert property (
    (cnt_q == 5'h0 && !ready_and_serial_out && !rise) |=> !ready_and_serial_out)
    else $error("ready released before first shift clock");
  a_bit_stands: assert property (
    (rise && cnt_q < 5'h18) |-> s_bit_stands)
    else $error("data bit not steady between shift clocks");
  a_forced_high: assert property (
    (rise && cnt_q == 5'h18) |-> s_forced_high)
    else $error("pin not forced high after final clock");
  a_fast_conv_time: assert property (
    (ready_fall && kind_q == 2'h1) |-> since_q + LO >= FAST_CONV_CYC + UPDATE_CYC
      && since_q <= FAST_CONV_CYC + UPDATE_CYC + HI)
    else $error("fast conversion time off");
  a_slow_conv_time: assert property (
    (ready_fall && kind_q == 2'h0) |-> since_q + LO >= SLOW_CONV_CYC + UPDATE_CYC
      && since_q <= SLOW_CONV_CYC + UPDATE_CYC + HI)
    else $error("low-noise conversion time off");
  a_cal_ready_time: assert property (
    (ready_fall && kind_q == 2'h2) |-> since_q + LO >= CAL_CYC + UPDATE_CYC
      && since_q <= CAL_CYC + UPDATE_CYC + HI)
    else $error("calibration time off");
  a_power_down_hold: assert property (
    ready_fall |-> armed_q)
    else $error("result appeared without start");
  a_start_width: assert property (
    $fell(start) |-> run_q >= START_MIN)
    else $error("start pulse too short");
  a_clock_after_ready: assert property (
    (rise && cnt_q == 5'h0) |-> !ready_and_serial_out)
    else $error("shift clock before ready");
  a_no_extra_clock: assert property (
    rise |-> cnt_q < 5'h1A)
    else $error("shift clock beyond calibration request");
endmodule // adc_link_checker

//--- verification/tb_top.sv
// Self-checking bench for the host and converter ends joined by one link.
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned FAST = 2000;
  localparam int unsigned SLOW = 3000;
  localparam int unsigned CAL = 2500;
  localparam int unsigned UPD = 50;
  localparam int LIMIT = 30000;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic mode_sel = 1'b0;
  logic continuous = 1'b0;
  logic single_req = 1'b0;
  logic cal_req = 1'b0;
  logic signed [31:0] sample_in = 32'sh0;
  logic converting, calibrating, result_valid_q, cal_done_q, busy;
  adc_pkg::result_t last_result, result_q;
  int bad_count = 0;
  int comparisons = 0;
  logic [56:0] cases [5];
  adc_link_if link();
  adc_device_end #(.FAST_CONV_CYC(FAST), .SLOW_CONV_CYC(SLOW), .CAL_CYC(CAL),
    .UPDATE_CYC(UPD), .AVG_N(16)) adc_device_end_inst (.clk_sys(clk_sys), .nrst(nrst),
    .link(link), .sample_in(sample_in), .converting(converting),
    .calibrating(calibrating), .last_result(last_result));
  adc_host_end #(.SCLK_HALF(10)) adc_host_end_inst (.clk_sys(clk_sys), .nrst(nrst),
    .link(link), .mode_sel(mode_sel), .continuous(continuous), .single_req(single_req),
    .cal_req(cal_req), .result_q(result_q), .result_valid_q(result_valid_q),
    .cal_done_q(cal_done_q), .busy(busy));
  adc_link_checker #(.FAST_CONV_CYC(FAST), .SLOW_CONV_CYC(SLOW), .CAL_CYC(CAL),
    .UPDATE_CYC(UPD)) adc_link_checker_inst (.clk_sys(clk_sys), .nrst(nrst),
    .start(link.start), .mode(link.mode), .sclk(link.sclk),
    .ready_and_serial_out(link.ready_and_serial_out));
  always #5 clk_sys = ~clk_sys;
  task automatic end_of_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp_word(input adc_pkg::result_t got, input adc_pkg::result_t exp,
    input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  function automatic logic hit(input int which);
    case (which)
      0: return result_valid_q === 1'b1;
      1: return cal_done_q === 1'b1;
      2: return calibrating === 1'b1;
      default: return busy === 1'b0 && converting === 1'b0;
    endcase
  endfunction
  // Every wait is bounded so that a stuck handshake ends the run with a verdict.
  task automatic wait_on(input int which);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (!hit(which) && n < LIMIT);
    if (!hit(which)) begin
      bad_count++;
      $display("wrong value at %0t: no event %0d in time", $time, which);
      end_of_test();
    end
  endtask
  task automatic pulse(input logic cal);
    @(negedge clk_sys);
    single_req = !cal;
    cal_req = cal;
    @(negedge clk_sys);
    single_req = 1'b0;
    cal_req = 1'b0;
  endtask
  task automatic settle(input string name);
    wait_on(3);
    repeat (3000) @(negedge clk_sys);
    cmp_bit(converting, 1'b0, "powered down");
    $display("test %s done: %0d compares, %0d mismatches", name, comparisons, bad_count);
  endtask
  initial begin
    cases[0] = {1'b1, 32'h00123456, 24'h123456};
    cases[1] = {1'b0, 32'h01000000, 24'h7FFFFF};
    cases[2] = {1'b0, 32'hFF000000, 24'h800000};
    cases[3] = {1'b0, 32'hFFFFF000, 24'hFFF000};
    cases[4] = {1'b1, 32'hFFFFFFFB, 24'hFFFFFB};
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      mode_sel = cases[i][56];
      sample_in = cases[i][55:24];
      repeat (4) @(negedge clk_sys);
      pulse(1'b0);
      wait_on(0);
      cmp_word(result_q, cases[i][23:0], "single result");
      cmp_word(last_result, cases[i][23:0], "device result");
      settle("single");
    end
    mode_sel = 1'b1;
    sample_in = 32'h0000ABCD;
    continuous = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wait_on(0);
      cmp_word(result_q, 24'h00ABCD, "continuous result");
    end
    continuous = 1'b0;
    settle("continuous");
    sample_in = 32'h00000777;
    pulse(1'b1);
    wait_on(0);
    cmp_word(result_q, 24'h000777, "result before calibration");
    wait_on(2);
    repeat (CAL - 10) @(negedge clk_sys);
    cmp_bit(calibrating, 1'b1, "calibration running");
    wait_on(1);
    wait_on(0);
    cmp_word(result_q, 24'h000000, "calibration result");
    settle("calibration");
    end_of_test();
  end
endmodule // tb_top
